//--- hw/tks_mod_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tks_mod_if;
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [7:0] slotWrData;
  logic slotWr;
  logic run;
  logic clearAll;
  logic sharedMode;
  logic mod0Ovf;
  logic [15:0] cfCnt;
  logic [7:0] slotCnt;
  logic slotOvf;
  logic cfOvf;
  logic done;
  logic [2:0] hopCode;
  modport top (output ctrl0, ctrl1, slotWrData, slotWr, run, clearAll, sharedMode, mod0Ovf,
               input cfCnt, slotCnt, slotOvf, cfOvf, done, hopCode);
  modport unit (input ctrl0, ctrl1, slotWrData, slotWr, run, clearAll, sharedMode, mod0Ovf,
                output cfCnt, slotCnt, slotOvf, cfOvf, done, hopCode);
endinterface : tks_mod_if
`default_nettype wire

//--- hw/tks_module.sv
`timescale 1ns/1ps
`default_nettype none
module tks_module
  import tks_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] keyOscIn,
  input wire logic refOscIn,
  input wire logic sysDiv4Tick,
  input wire logic [3:0] keyPresent,
  tks_mod_if.unit bus,
  output logic [3:0] keyPinTouch,
  output logic [3:0] keyOscRun,
  output logic refOscRun
);
  logic [4:0] syncA, syncB, syncC, oscLevel;
  logic [4:0] next_oscLevel;
  logic [4:0] unitCnt;
  logic [15:0] cfCnt, cfResult;
  logic [7:0] slotCnt;
  logic [2:0] hwHop;
  logic stopped;
  wire active = bus.run & ~stopped;
  wire [3:0] keyEdge;
  wire refEdge;
  wire slotTick;
  wire unitWrap;
  wire stopEv;
  wire [1:0] muxSel = bus.ctrl0[C0_MUX_LO +: 2];
  wire keyCount;

  // Pin filter: a level counts once the second and third stages agree
  assign next_oscLevel = (syncB & ~(syncB ^ syncC)) | (oscLevel & (syncB ^ syncC));
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
      syncC <= 5'h00;
      oscLevel <= 5'h00;
    end else begin
      syncA <= {refOscIn, keyOscIn};
      syncB <= syncA;
      syncC <= syncB;
      oscLevel <= next_oscLevel;
    end
  end
  assign keyEdge = next_oscLevel[3:0] & ~oscLevel[3:0];
  assign refEdge = next_oscLevel[4] & ~oscLevel[4];

  // Pin function and oscillator gating
  assign keyPinTouch = bus.ctrl1[3:0] & keyPresent;
  assign keyOscRun = {4{bus.ctrl1[C1_KEY_EN] & active}} & keyPinTouch;
  assign refOscRun = bus.ctrl1[C1_REF_EN] & active;
  // Slot clock: reference oscillator only counts while it runs
  assign slotTick = active & (bus.ctrl1[C1_SLOT_SRC] ? sysDiv4Tick : (refEdge & refOscRun));
  assign unitWrap = slotTick & (unitCnt == UNIT_LAST);
  assign bus.slotOvf = unitWrap & (slotCnt == SLOT_LAST);
  assign stopEv = active & (bus.sharedMode ? bus.mod0Ovf : bus.slotOvf);
  assign keyCount = keyEdge[muxSel] & keyOscRun[muxSel];
  assign bus.cfOvf = active & keyCount & (cfCnt == CNT16_LAST);
  assign bus.done = stopped;
  assign bus.slotCnt = slotCnt;
  assign bus.cfCnt = stopped ? cfResult : cfCnt;
  assign bus.hopCode = bus.ctrl0[C0_HOP_CTRL] ? hwHop : bus.ctrl0[2:0];

  // Stop state: armed by start rising, ended by overflow
  // Scan end also parks modules that never overflow, or they would run on
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stopped <= 1'b0;
    end else if (!bus.run) begin
      stopped <= 1'b0;
    end else if (stopEv || bus.clearAll) begin
      stopped <= 1'b1;
    end
  end

  // Unit period prescaler
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      unitCnt <= 5'h00;
    end else if (!bus.run || bus.clearAll) begin
      unitCnt <= 5'h00;
    end else if (slotTick) begin
      unitCnt <= unitCnt + 5'h01;
    end
  end

  // Slot counter keeps its value while start is low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slotCnt <= RST_SLOT;
    end else if (bus.slotWr) begin
      slotCnt <= bus.slotWrData;
    end else if (bus.clearAll) begin
      slotCnt <= 8'h00;
    end else if (unitWrap) begin
      slotCnt <= slotCnt + 8'h01;
    end
  end

  // Frequency counter, result captured at stop so the clear cannot lose it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfCnt <= 16'h0000;
      cfResult <= 16'h0000;
    end else if (!bus.run) begin
      cfCnt <= 16'h0000;
      cfResult <= 16'h0000;
    end else begin
      if (bus.clearAll) begin
        cfCnt <= 16'h0000;
      end else if (active && keyCount) begin
        cfCnt <= cfCnt + 16'h0001;
      end
      if (stopEv || (bus.clearAll && !stopped)) begin
        cfResult <= cfCnt;
      end
    end
  end

  // Hardware hopping steps once per unit period
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hwHop <= 3'h0;
    end else if (unitWrap) begin
      hwHop <= hwHop + 3'h1;
    end
  end

  a_ctr_clear_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    !bus.run |=> (unitCnt == 5'h00) && (cfCnt == 16'h0000))
    else $error("counters not cleared while start low");
  a_osc_stop_ovf: assert property (@(posedge ref_clk) disable iff (!resetn)
    stopEv && bus.run |=> !refOscRun && (keyOscRun == 4'h0))
    else $error("oscillators still run after overflow");
  a_hop_field_sel: assert property (@(posedge ref_clk) disable iff (!resetn)
    !bus.ctrl0[C0_HOP_CTRL] |-> bus.hopCode == bus.ctrl0[2:0])
    else $error("hop code does not follow field");
  a_absent_key_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    (keyPinTouch & ~keyPresent) == 4'h0 && (keyOscRun & ~keyPresent) == 4'h0)
    else $error("absent key became active");
endmodule : tks_module
`default_nettype wire

//--- hw/tks_pkg.sv
package tks_pkg;
  localparam int NMOD = 5;
  localparam int NKEY = 20;
  // Register map
  localparam logic [7:0] ADDR_SCAN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FUNC_LO = 8'h01;
  localparam logic [7:0] ADDR_FUNC_HI = 8'h02;
  localparam logic [4:0] MOD_BLOCK_BASE = 5'h02;
  localparam logic [2:0] OFS_CTRL0 = 3'h0;
  localparam logic [2:0] OFS_CTRL1 = 3'h1;
  localparam logic [2:0] OFS_CNT_LO = 3'h2;
  localparam logic [2:0] OFS_CNT_HI = 3'h3;
  localparam logic [2:0] OFS_SLOT = 3'h4;
  // Scan control fields
  localparam int SC_START = 6;
  localparam int SC_SLOT_OVF = 5;
  localparam int SC_CF_OVF = 4;
  localparam int SC_FUNC_OVF = 3;
  localparam int SC_SHARED = 2;
  localparam int SC_CLKSEL_LO = 0;
  // Module control fields
  localparam int C0_HOP_CTRL = 3;
  localparam int C0_MUX_LO = 6;
  localparam int C1_SLOT_SRC = 7;
  localparam int C1_REF_EN = 5;
  localparam int C1_KEY_EN = 4;
  // Reset values and masks
  localparam logic [7:0] RST_SCAN_CTRL = 8'h00;
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_SLOT = 8'h00;
  localparam logic [7:0] CTRL1_WR_MASK = 8'hBF;
  // Counter limits
  localparam logic [4:0] UNIT_LAST = 5'h1F;
  localparam logic [7:0] SLOT_LAST = 8'hFF;
  localparam logic [15:0] CNT16_LAST = 16'hFFFF;
  localparam logic [1:0] DIV4_PHASE = 2'h3;

  typedef enum logic [1:0] {
    TKS_IDLE = 2'b00,
    TKS_RUN = 2'b01,
    TKS_DONE = 2'b10
  } tks_scan_t;

  // Divide-by-1/2/4/8 tick from a free 3-bit count
  function automatic logic tks_div_tick(input logic [2:0] cnt, input logic [1:0] sel);
    case (sel)
      2'h0: tks_div_tick = 1'b1;
      2'h1: tks_div_tick = cnt[0];
      2'h2: tks_div_tick = &cnt[1:0];
      default: tks_div_tick = &cnt;
    endcase
  endfunction : tks_div_tick

  // Module register block hit
  function automatic logic tks_mod_hit(input logic [7:0] addr, input logic [4:0] n);
    tks_mod_hit = (addr[7:3] == 5'(MOD_BLOCK_BASE + n));
  endfunction : tks_mod_hit
endpackage : tks_pkg

//--- hw/tks_top.sv
`timescale 1ns/1ps
`default_nettype none
module tks_top
  import tks_pkg::*;
#(
  parameter logic [NKEY-1:0] KEY_PRESENT = 20'hFFFFF
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [NKEY-1:0] keyOscIn,
  input wire logic [NMOD-1:0] refOscIn,
  output logic [NKEY-1:0] keyPinTouch,
  output logic [NKEY-1:0] keyOscRun,
  output logic [NMOD-1:0] refOscRun,
  output logic [3*NMOD-1:0] hopFreqSelect,
  output logic touchIrq
);
  tks_mod_if bus [NMOD] ();

  // Scan control register
  logic scanStart;
  logic sharedSlotSelect;
  logic [1:0] funcCounterClkSel;
  logic slotCounterOvfFlag;
  logic freqCounterOvfFlag;
  logic funcCounterOvfFlag;
  // Per-module control storage
  logic [7:0] ctrl0Reg [NMOD];
  logic [7:0] ctrl1Reg [NMOD];
  // Function counter and its captured result
  logic [15:0] funcCnt;
  logic [15:0] funcResult;
  logic [2:0] divCnt;
  tks_scan_t scanState;
  tks_scan_t next_scanState;

  // Gathered module status
  logic [NMOD-1:0] modDone;
  logic [NMOD-1:0] modEnabled;
  logic [NMOD-1:0] modCfOvf;
  logic [15:0] modCfCnt [NMOD];
  logic [7:0] modSlotCnt [NMOD];

  // Address decode
  wire scanCtrlHit = (regAddr == ADDR_SCAN_CTRL);
  wire funcLoHit = (regAddr == ADDR_FUNC_LO);
  wire funcHiHit = (regAddr == ADDR_FUNC_HI);
  wire [2:0] modOfs = regAddr[2:0];
  wire scanCtrlWr = regWr & scanCtrlHit;
  wire [7:0] scanCtrlView = {1'b0, scanStart, slotCounterOvfFlag, freqCounterOvfFlag,
                             funcCounterOvfFlag, sharedSlotSelect, funcCounterClkSel};

  // Divider for sysclk/4 slot clock and function counter clock
  wire sysDiv4Tick = (divCnt[1:0] == DIV4_PHASE);
  wire funcTick = tks_div_tick(divCnt, funcCounterClkSel);
  wire funcActive = (scanState == TKS_RUN);
  wire funcOvf = funcActive & funcTick & (funcCnt == CNT16_LAST);

  // Interrupt: shared mode waits on module 0, otherwise on module 0 and every enabled module
  wire allDone = sharedSlotSelect ? modDone[0]
                                  : &(modDone | ~(modEnabled | {{(NMOD-1){1'b0}}, 1'b1}));
  wire scanEnd = (scanState == TKS_RUN) & allDone;
  wire clearAll = scanEnd;

  // Per-module wiring through the carrier interface
  genvar g;
  generate
    for (g = 0; g < NMOD; g++) begin : gMod
      wire modWrHit = regWr & tks_mod_hit(regAddr, 5'(g));
      assign bus[g].ctrl0 = ctrl0Reg[g];
      assign bus[g].ctrl1 = ctrl1Reg[g];
      assign bus[g].slotWr = modWrHit & (modOfs == OFS_SLOT);
      assign bus[g].slotWrData = regWrData;
      assign bus[g].run = scanStart;
      assign bus[g].clearAll = clearAll;
      assign bus[g].sharedMode = sharedSlotSelect;
      assign bus[g].mod0Ovf = bus[0].slotOvf;
      assign modDone[g] = bus[g].done;
      assign modCfOvf[g] = bus[g].cfOvf;
      assign modCfCnt[g] = bus[g].cfCnt;
      assign modSlotCnt[g] = bus[g].slotCnt;
      assign modEnabled[g] = |keyPinTouch[4*g +: 4];
      assign hopFreqSelect[3*g +: 3] = bus[g].hopCode;

      // Module n serves keys 4n+1 to 4n+4
      tks_module uModule (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .keyOscIn(keyOscIn[4*g +: 4]),
        .refOscIn(refOscIn[g]),
        .sysDiv4Tick(sysDiv4Tick),
        .keyPresent(KEY_PRESENT[4*g +: 4]),
        .bus(bus[g]),
        .keyPinTouch(keyPinTouch[4*g +: 4]),
        .keyOscRun(keyOscRun[4*g +: 4]),
        .refOscRun(refOscRun[g])
      );
    end
  endgenerate

  // Module register writes, indexed by the address block
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NMOD; i++) begin
        ctrl0Reg[i] <= RST_CTRL0;
        ctrl1Reg[i] <= RST_CTRL1;
      end
    end else if (regWr && regAddr[7:3] >= MOD_BLOCK_BASE &&
                 regAddr[7:3] < 5'(MOD_BLOCK_BASE + NMOD)) begin
      if (modOfs == OFS_CTRL0) begin
        ctrl0Reg[3'(regAddr[7:3] - MOD_BLOCK_BASE)] <= regWrData;
      end else if (modOfs == OFS_CTRL1) begin
        ctrl1Reg[3'(regAddr[7:3] - MOD_BLOCK_BASE)] <= regWrData & CTRL1_WR_MASK;
      end
    end
  end

  // Scan control writable fields
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scanStart <= RST_SCAN_CTRL[SC_START];
      sharedSlotSelect <= RST_SCAN_CTRL[SC_SHARED];
      funcCounterClkSel <= RST_SCAN_CTRL[SC_CLKSEL_LO +: 2];
    end else if (scanCtrlWr) begin
      scanStart <= regWrData[SC_START];
      sharedSlotSelect <= regWrData[SC_SHARED];
      funcCounterClkSel <= regWrData[SC_CLKSEL_LO +: 2];
    end
  end

  // Sticky flags: hardware set wins over a software write of zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slotCounterOvfFlag <= RST_SCAN_CTRL[SC_SLOT_OVF];
      freqCounterOvfFlag <= RST_SCAN_CTRL[SC_CF_OVF];
      funcCounterOvfFlag <= RST_SCAN_CTRL[SC_FUNC_OVF];
    end else begin
      if (scanEnd) begin
        slotCounterOvfFlag <= 1'b1;
      end else if (scanCtrlWr && !regWrData[SC_SLOT_OVF]) begin
        slotCounterOvfFlag <= 1'b0;
      end
      if (|modCfOvf) begin
        freqCounterOvfFlag <= 1'b1;
      end else if (scanCtrlWr && !regWrData[SC_CF_OVF]) begin
        freqCounterOvfFlag <= 1'b0;
      end
      if (funcOvf) begin
        funcCounterOvfFlag <= 1'b1;
      end else if (scanCtrlWr && !regWrData[SC_FUNC_OVF]) begin
        funcCounterOvfFlag <= 1'b0;
      end
    end
  end

  // Scan phase; a new scan needs start to fall and rise again
  always_comb begin
    next_scanState = scanState;
    case (scanState)
      TKS_IDLE: begin
        if (scanStart) begin
          next_scanState = TKS_RUN;
        end
      end
      TKS_RUN: begin
        if (!scanStart) begin
          next_scanState = TKS_IDLE;
        end else if (allDone) begin
          next_scanState = TKS_DONE;
        end
      end
      TKS_DONE: begin
        if (!scanStart) begin
          next_scanState = TKS_IDLE;
        end
      end
      default: next_scanState = TKS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scanState <= TKS_IDLE;
    end else begin
      scanState <= next_scanState;
    end
  end

  // Free running divider
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt <= 3'h0;
    end else begin
      divCnt <= divCnt + 3'h1;
    end
  end

  // Function counter, captured at scan end before the clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      funcCnt <= 16'h0000;
      funcResult <= 16'h0000;
    end else if (!scanStart) begin
      funcCnt <= 16'h0000;
      funcResult <= 16'h0000;
    end else if (scanEnd) begin
      funcResult <= funcCnt;
      funcCnt <= 16'h0000;
    end else if (funcActive && funcTick) begin
      funcCnt <= funcCnt + 16'h0001;
    end
  end

  // One interrupt pulse per scan
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      touchIrq <= 1'b0;
    end else begin
      touchIrq <= scanEnd;
    end
  end

  // Read data, valid only in the cycle after the strobe
  logic [7:0] rdMux;
  logic [2:0] rdIdx;
  always_comb begin
    rdMux = 8'h00;
    rdIdx = 3'(regAddr[7:3] - MOD_BLOCK_BASE);
    if (scanCtrlHit) begin
      rdMux = scanCtrlView;
    end else if (funcLoHit) begin
      rdMux = (scanState == TKS_DONE) ? funcResult[7:0] : funcCnt[7:0];
    end else if (funcHiHit) begin
      rdMux = (scanState == TKS_DONE) ? funcResult[15:8] : funcCnt[15:8];
    end else if (regAddr[7:3] >= MOD_BLOCK_BASE &&
                 regAddr[7:3] < 5'(MOD_BLOCK_BASE + NMOD)) begin
      case (modOfs)
        OFS_CTRL0: rdMux = ctrl0Reg[rdIdx];
        OFS_CTRL1: rdMux = ctrl1Reg[rdIdx] & CTRL1_WR_MASK;
        OFS_CNT_LO: rdMux = modCfCnt[rdIdx][7:0];
        OFS_CNT_HI: rdMux = modCfCnt[rdIdx][15:8];
        OFS_SLOT: rdMux = modSlotCnt[rdIdx];
        default: rdMux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end

  // Checks
  sequence s_scan_end;
    scanState == TKS_RUN && allDone;
  endsequence
  sequence s_irq_follow;
    ##1 touchIrq ##1 !touchIrq;
  endsequence

  a_irq_once: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_scan_end |-> s_irq_follow)
    else $error("interrupt not a single pulse after scan end");
  a_irq_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
    touchIrq |-> $past(scanState) == TKS_RUN && slotCounterOvfFlag)
    else $error("interrupt without slot overflow");
  a_clear_all: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_scan_end ##1 scanStart |-> funcCnt == 16'h0000 && modSlotCnt[0] == 8'h00)
    else $error("counters not cleared at scan end");
  a_func_clear_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    !scanStart |=> funcCnt == 16'h0000)
    else $error("function counter not held at zero");
  a_func_ovf_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    funcCounterOvfFlag && !scanCtrlWr |=> funcCounterOvfFlag)
    else $error("function overflow flag dropped by itself");
  a_cf_ovf_set: assert property (@(posedge ref_clk) disable iff (!resetn)
    |modCfOvf |=> freqCounterOvfFlag)
    else $error("frequency overflow flag not set");
  a_ctrl1_bit6: assert property (@(posedge ref_clk) disable iff (!resetn)
    regRd && regAddr[7:3] == MOD_BLOCK_BASE && modOfs == OFS_CTRL1 |=> !regRdData[6])
    else $error("unimplemented bit reads one");
  a_func_div8: assert property (@(posedge ref_clk) disable iff (!resetn)
    funcActive && funcCounterClkSel == 2'h3 && funcTick |=> !funcTick [*7] ##1 funcTick)
    else $error("divide by eight tick spacing wrong");
  a_shared_stop: assert property (@(posedge ref_clk) disable iff (!resetn)
    scanState == TKS_RUN && sharedSlotSelect && modDone[0] |=> scanState != TKS_RUN)
    else $error("shared mode ignored module 0 overflow");
endmodule : tks_top
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tks_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic [NKEY-1:0] keyOscIn = '0;
  logic [NMOD-1:0] refOscIn = '0;
  logic [NKEY-1:0] keyPinTouch;
  logic [NKEY-1:0] keyOscRun;
  logic [NMOD-1:0] refOscRun;
  logic [3*NMOD-1:0] hopFreqSelect;
  logic touchIrq;
  int errorCnt = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hB65AD50E;

  tks_top tks_top_inst (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .keyOscIn(keyOscIn),
    .refOscIn(refOscIn), .keyPinTouch(keyPinTouch), .keyOscRun(keyOscRun),
    .refOscRun(refOscRun), .hopFreqSelect(hopFreqSelect), .touchIrq(touchIrq)
  );

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  // Key oscillator pins jitter from the LFSR so edges are irregular
  always @(posedge ref_clk) begin
    keyOscIn <= keyOscIn ^ seed[19:0];
    if (cycles[1:0] == 2'h0) begin
      refOscIn <= ~refOscIn; // Period of eight cycles, slow enough for the pin filter
    end
    seed <= lfsr(seed);
  end

  // Hang guard, well above six scans of some 130 to 260 cycles each
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errorCnt++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [7:0] modAddr(input int n, input logic [2:0] ofs);
    modAddr = {5'(MOD_BLOCK_BASE + 5'(n)), ofs};
  endfunction : modAddr

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  task automatic cmpReg(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmpReg

  task automatic cmpPins(input logic [NKEY-1:0] got, input logic [NKEY-1:0] exp,
                         input string what);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmpPins

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Run one scan and wait for the interrupt pulse, bounded
  task automatic scan(input logic [7:0] ctrl, output int len);
    wr(ADDR_SCAN_CTRL, ctrl);
    len = 0;
    while (touchIrq !== 1'b1 && len < 1000) begin
      @(posedge ref_clk);
      #1 len++;
    end
  endtask : scan

  logic [7:0] d;
  logic [7:0] lo;
  logic [NKEY-1:0] expKeys;
  int len;

  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values, unmapped place
    rd(ADDR_SCAN_CTRL, d);
    cmpReg(d, RST_SCAN_CTRL, "scan ctrl reset");
    for (int n = 0; n < NMOD; n++) begin
      rd(modAddr(n, OFS_CTRL1), d);
      cmpReg(d, RST_CTRL1, "ctrl1 reset");
    end
    wr(8'hF0, 8'hA5);
    rd(8'hF0, d);
    cmpReg(d, 8'h00, "unmapped");
    $display("test reset done");
    // Random control-1 values; bit 6 never reads back
    expKeys = '0;
    for (int n = 0; n < NMOD; n++) begin
      d = seed[7:0] | 8'h40;
      wr(modAddr(n, OFS_CTRL1), d);
      expKeys[4*n+:4] = d[3:0];
      rd(modAddr(n, OFS_CTRL1), lo);
      cmpReg(lo, d & CTRL1_WR_MASK, "ctrl1 readback");
    end
    cmpPins(keyPinTouch, expKeys, "key pins");
    $display("test ctrl1 done");
    // Every hop code in manual mode
    for (int c = 0; c < 8; c++) begin
      wr(modAddr(2, OFS_CTRL0), 8'(c));
      #1 cmpReg({5'h0, hopFreqSelect[8:6]}, 8'(c), "hop select");
    end
    // Hardware hopping ignores the field; count idle until a unit period passes
    wr(modAddr(2, OFS_CTRL0), 8'h0F);
    #1 cmpReg({5'h0, hopFreqSelect[8:6]}, 8'h00, "hop hardware");
    wr(modAddr(2, OFS_CTRL0), 8'h00);
    $display("test hop done");
    // Own-slot scans, every function clock divider
    for (int n = 0; n < NMOD; n++) wr(modAddr(n, OFS_CTRL1), (n == 0) ? 8'hBF : 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(modAddr(0, OFS_SLOT), SLOT_LAST);
      scan(8'h40 | 8'(s), len);
      cmpReg(8'(len >= 125 && len <= 140), 8'h01, "slot period");
      @(posedge ref_clk);
      #1 cmpReg({7'h0, touchIrq}, 8'h00, "irq one cycle");
      cmpPins(keyOscRun, '0, "osc stopped");
      cmpPins(NKEY'(refOscRun), '0, "ref osc stopped");
      rd(ADDR_SCAN_CTRL, d);
      cmpReg(d, 8'h60 | 8'(s), "slot flag set");
      rd(ADDR_FUNC_LO, lo);
      // Counting spans len-2 edges; a divided tick lands floor or ceil times in it
      cmpReg(8'(int'(lo) >= ((len - 2) >> s) && int'(lo) <= ((len - 2) >> s) + 1), 8'h01, "func count");
      rd(modAddr(0, OFS_CNT_LO), lo);
      cmpReg(8'(lo != 0), 8'h01, "key count");
      wr(ADDR_SCAN_CTRL, 8'h00);
      rd(ADDR_SCAN_CTRL, d);
      cmpReg(d, 8'h00, "flag cleared");
      rd(ADDR_FUNC_LO, lo);
      cmpReg(lo, 8'h00, "func cleared");
      rd(modAddr(0, OFS_CNT_LO), lo);
      cmpReg(lo, 8'h00, "key count cleared");
    end
    // Reference oscillator as slot clock, key mux on a disabled key
    wr(modAddr(0, OFS_CTRL0), 8'hC0);
    wr(modAddr(0, OFS_CTRL1), 8'h31);
    wr(modAddr(0, OFS_SLOT), SLOT_LAST);
    wr(ADDR_SCAN_CTRL, 8'h40);
    #1 cmpPins(keyOscRun, 20'h00001, "key osc running");
    cmpPins(NKEY'(refOscRun), 20'h00001, "ref osc running");
    scan(8'h40, len);
    cmpReg(8'(len >= 245 && len <= 265), 8'h01, "ref slot period");
    rd(modAddr(0, OFS_CNT_LO), lo);
    cmpReg(lo, 8'h00, "muxed key idle");
    $display("test ref scan done");
    // Slot counter survives a low start bit
    wr(modAddr(0, OFS_SLOT), 8'h37);
    wr(ADDR_SCAN_CTRL, 8'h00);
    rd(modAddr(0, OFS_SLOT), d);
    cmpReg(d, 8'h37, "slot kept");
    $display("test own scan done");
    // Shared slot: module 1 has a slow slot but follows module 0
    wr(modAddr(0, OFS_CTRL1), 8'h80);
    wr(modAddr(1, OFS_CTRL1), 8'h3F);
    wr(modAddr(1, OFS_SLOT), 8'h00);
    wr(modAddr(0, OFS_SLOT), SLOT_LAST);
    scan(8'h44, len);
    cmpReg(8'(len >= 125 && len <= 140), 8'h01, "shared period");
    rd(ADDR_SCAN_CTRL, d);
    cmpReg(d, 8'h64, "shared flag");
    cmpPins(keyOscRun, '0, "shared keys stopped");
    cmpPins(NKEY'(refOscRun), '0, "shared ref stopped");
    $display("test shared scan done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
